// *** rcb_core.sv ***
// Circular buffer mode 2 message storage and mode command handling for a remote terminal.
// Assumes a shared RAM that answers a read one cycle after the registered request,
// and a protocol front end that reports commands, words and message end as pulses.
//
// Operation
// - Receive words stored from current data pointer
// - After words, write info, time tag, pointers
// - Before block end, pointers advance to next
// - Block end reloads pointers; count field masks
// - Block done interrupt when both enables set
// - Transmit words fetched from current data pointer
// - Transmit end updates like receive
// - Broadcast data shares the one buffer
// - Broadcast flag replaces gap error bit
// - Broadcast transmit: no send, pointers held
// - Invalid option covers only 22 undefined codes
// - Option cleared at reset; undefined then valid
// - Legal mode command answered in form
// - Illegal mode command sets message error
// - Invalid undefined code: silence, status kept
// - Table resets clear; non-broadcast transmit codes 16 to 31 send data
// - Dynamic bus acceptance never set
// - Mode interrupts from top control bits
// - Access interrupt sets pending and output
// - Access interrupt logged before output asserts; block done not logged
// - Logged address is mode control word address
// - Info pointer held after error, busy, illegal
// - Increment once, test full, else again
`timescale 1ns/10ps

module rcb_core (
  input wire logic clk,
  input wire logic rst,
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  input wire logic cmd_valid,
  input wire rcb_pkg::rcb_cmd_t cmd,
  input wire logic rx_word_valid,
  input wire logic [15:0] rx_word,
  input wire logic tx_word_req,
  output logic tx_word_valid,
  output logic [15:0] tx_word,
  input wire logic msg_end,
  input wire rcb_pkg::rcb_msg_stat_t msg_stat,
  input wire logic [15:0] time_tag,
  output logic resp_valid,
  output rcb_pkg::rcb_resp_t resp,
  output logic [15:0] ram_addr,
  output logic [15:0] ram_wdata,
  output logic ram_we,
  output logic ram_re,
  input wire logic [15:0] ram_rdata,
  output logic message_irq_output
);

  // ************************************************************
  // Registers
  // ************************************************************
  logic [15:0] cfg_r;
  logic [15:0] irq_en_r;
  logic [15:0] pend_r;
  logic [15:0] desc_base_r;
  logic [15:0] log_base_r;
  logic [15:0] ill_r [0:7];
  logic msg_error_status_r;
  logic [rcb_pkg::LOGW-1:0] log_ptr_r;
  logic [15:0] tt_r;

  rcb_pkg::rcb_state_t state_r;
  rcb_pkg::rcb_cmd_t cmd_r;
  rcb_pkg::rcb_msg_stat_t stat_r;
  logic [15:0] desc_r;
  logic [15:0] ctrl_r;
  logic [15:0] start_r;
  logic [15:0] current_data_pointer;
  logic [15:0] info_buffer_pointer;
  logic [2:0] k_r;
  logic [5:0] cnt_r;
  logic [1:0] txp_r;
  logic set_block_r;
  logic set_access_r;
  logic [15:0] ram_addr_r;
  logic [15:0] ram_wdata_r;
  logic ram_we_r;
  logic ram_re_r;

  // ************************************************************
  // Mode command decode
  // ************************************************************
  logic is_mode;
  logic undefined_mc;
  logic ill_bit;
  logic recognized;
  logic [6:0] ill_idx;
  logic [15:0] mib_inc;
  logic [15:0] cnt_mask;
  logic full_count;
  logic hold_ptrs;
  logic [15:0] miw;

  assign is_mode = (cmd.sa == 5'h00) || (cmd.sa == 5'h1f);
  assign undefined_mc = cmd.tr ? (cmd.wc_mc == 5'h11 || cmd.wc_mc == 5'h14 || cmd.wc_mc == 5'h15)
                               : (cmd.wc_mc <= 5'h10 || cmd.wc_mc == 5'h12 || cmd.wc_mc == 5'h13);
  assign ill_idx = {cmd.broadcast_indicator, cmd.tr, cmd.wc_mc};
  assign ill_bit = ill_r[ill_idx[6:4]][ill_idx[3:0]];
  assign recognized = !(undefined_mc && cfg_r[rcb_pkg::CFG_UNDEF_INV]);

  assign mib_inc = info_buffer_pointer + 16'h0001;
  assign cnt_mask = (16'h0001 << ctrl_r[rcb_pkg::CTL_CNT_LSB +: 4]) - 16'h0001;
  assign full_count = (mib_inc & cnt_mask) == cnt_mask;
  // Pointers held on error or broadcast transmit
  assign hold_ptrs = stat_r.error || stat_r.busy || stat_r.illegal || (cmd_r.broadcast_indicator && cmd_r.tr);

  always_comb begin
    miw = {11'h000, cmd_r.wc_mc};
    miw[rcb_pkg::MIW_ERROR] = stat_r.error;
    miw[rcb_pkg::MIW_BUSY] = stat_r.busy;
    miw[rcb_pkg::MIW_ILLEGAL] = stat_r.illegal;
    miw[rcb_pkg::MIW_BROADCAST_INDICATOR] = cfg_r[rcb_pkg::CFG_BROADCAST_INDICATOR_FLAG] ? cmd_r.broadcast_indicator : stat_r.gap_err;
  end

  // ************************************************************
  // Register port
  // ************************************************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cfg_r <= rcb_pkg::CFG_RST;
      irq_en_r <= rcb_pkg::ZERO16;
      desc_base_r <= rcb_pkg::ZERO16;
      log_base_r <= rcb_pkg::ZERO16;
    end else if (reg_wr) begin
      unique case (reg_addr)
        rcb_pkg::REG_CFG: cfg_r <= reg_wdata;
        rcb_pkg::REG_IRQ_EN: irq_en_r <= reg_wdata;
        rcb_pkg::REG_DESC_BASE: desc_base_r <= reg_wdata;
        rcb_pkg::REG_LOG_BASE: log_base_r <= reg_wdata;
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < 8; i++) begin
        ill_r[i] <= rcb_pkg::ZERO16;
      end
    end else if (reg_wr && reg_addr[3]) begin
      ill_r[reg_addr[2:0]] <= reg_wdata;
    end
  end

  // Set wins over a same-cycle clear
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pend_r <= rcb_pkg::ZERO16;
    end else begin
      pend_r <= (pend_r & ~((reg_wr && reg_addr == rcb_pkg::REG_PEND) ? reg_wdata : rcb_pkg::ZERO16))
                | {14'h0000, set_access_r, set_block_r};
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= rcb_pkg::ZERO16;
    end else if (reg_rd) begin
      if (reg_addr[3]) begin
        reg_rdata <= ill_r[reg_addr[2:0]];
      end else begin
        unique case (reg_addr)
          rcb_pkg::REG_CFG: reg_rdata <= cfg_r;
          rcb_pkg::REG_IRQ_EN: reg_rdata <= irq_en_r;
          rcb_pkg::REG_PEND: reg_rdata <= pend_r;
          rcb_pkg::REG_DESC_BASE: reg_rdata <= desc_base_r;
          rcb_pkg::REG_LOG_BASE: reg_rdata <= log_base_r;
          rcb_pkg::REG_STATUS: reg_rdata <= {7'h00, msg_error_status_r, log_ptr_r, state_r};
          default: reg_rdata <= rcb_pkg::ZERO16;
        endcase
      end
    end else begin
      reg_rdata <= rcb_pkg::ZERO16;
    end
  end

  // ************************************************************
  // Message sequencer
  // ************************************************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_r <= rcb_pkg::ST_IDLE;
      cmd_r <= '0;
      stat_r <= '0;
      desc_r <= rcb_pkg::ZERO16;
      ctrl_r <= rcb_pkg::ZERO16;
      start_r <= rcb_pkg::ZERO16;
      current_data_pointer <= rcb_pkg::ZERO16;
      info_buffer_pointer <= rcb_pkg::ZERO16;
      tt_r <= rcb_pkg::ZERO16;
      k_r <= 3'h0;
      cnt_r <= 6'h00;
      ram_addr_r <= rcb_pkg::ZERO16;
      ram_wdata_r <= rcb_pkg::ZERO16;
      ram_we_r <= 1'b0;
      ram_re_r <= 1'b0;
      set_block_r <= 1'b0;
      set_access_r <= 1'b0;
      log_ptr_r <= '0;
    end else begin
      ram_we_r <= 1'b0;
      ram_re_r <= 1'b0;
      set_block_r <= 1'b0;
      set_access_r <= 1'b0;
      unique case (state_r)
        rcb_pkg::ST_IDLE: begin
          if (cmd_valid && is_mode && recognized) begin
            cmd_r <= cmd;
            desc_r <= desc_base_r + rcb_pkg::DESC_MODE_OFS + {8'h00, cmd.tr, cmd.wc_mc, 2'b00};
            state_r <= rcb_pkg::ST_MRD;
          end else if (cmd_valid && !is_mode) begin
            cmd_r <= cmd;
            desc_r <= desc_base_r + {8'h00, cmd.tr, cmd.sa, 2'b00};
            k_r <= 3'h0;
            cnt_r <= 6'h00;
            state_r <= rcb_pkg::ST_DESC;
          end
        end
        rcb_pkg::ST_DESC: begin
          // Reads are pipelined: word j lands two steps after its request
          if (k_r < rcb_pkg::DESC_WORDS) begin
            ram_re_r <= 1'b1;
            ram_addr_r <= desc_r + {13'h0000, k_r};
          end
          if (k_r == 3'h2) ctrl_r <= ram_rdata;
          if (k_r == 3'h3) start_r <= ram_rdata;
          if (k_r == 3'h4) current_data_pointer <= ram_rdata;
          if (k_r == 3'h5) begin
            info_buffer_pointer <= ram_rdata;
            state_r <= rcb_pkg::ST_XFER;
          end
          k_r <= k_r + 3'h1;
        end
        rcb_pkg::ST_XFER: begin
          // Broadcast and non-broadcast receive data to one buffer
          if (rx_word_valid && !cmd_r.tr) begin
            ram_we_r <= 1'b1;
            ram_addr_r <= current_data_pointer + {10'h000, cnt_r};
            ram_wdata_r <= rx_word;
            cnt_r <= cnt_r + 6'h01;
          end else if (tx_word_req && cmd_r.tr && !cmd_r.broadcast_indicator) begin
            ram_re_r <= 1'b1;
            ram_addr_r <= current_data_pointer + {10'h000, cnt_r};
            cnt_r <= cnt_r + 6'h01;
          end else if (msg_end) begin
            stat_r <= msg_stat;
            tt_r <= time_tag;
            state_r <= rcb_pkg::ST_MIW;
          end
        end
        rcb_pkg::ST_MIW: begin
          ram_we_r <= 1'b1;
          ram_addr_r <= info_buffer_pointer;
          ram_wdata_r <= miw;
          state_r <= rcb_pkg::ST_TT;
        end
        rcb_pkg::ST_TT: begin
          ram_we_r <= 1'b1;
          ram_addr_r <= mib_inc;
          ram_wdata_r <= tt_r;
          state_r <= hold_ptrs ? rcb_pkg::ST_IDLE : rcb_pkg::ST_CA;
        end
        rcb_pkg::ST_CA: begin
          ram_we_r <= 1'b1;
          ram_addr_r <= desc_r + rcb_pkg::DESC_CA_OFS;
          current_data_pointer <= full_count ? start_r : current_data_pointer + {10'h000, cnt_r};
          ram_wdata_r <= full_count ? start_r : current_data_pointer + {10'h000, cnt_r};
          state_r <= rcb_pkg::ST_MIB;
        end
        rcb_pkg::ST_MIB: begin
          ram_we_r <= 1'b1;
          ram_addr_r <= desc_r + rcb_pkg::DESC_MIB_OFS;
          info_buffer_pointer <= full_count ? (info_buffer_pointer & ~cnt_mask) : info_buffer_pointer + 16'h0002;
          ram_wdata_r <= full_count ? (info_buffer_pointer & ~cnt_mask) : info_buffer_pointer + 16'h0002;
          set_block_r <= full_count && ctrl_r[rcb_pkg::CTL_BLOCK_DONE] && irq_en_r[rcb_pkg::IRQ_BLOCK_DONE];
          state_r <= rcb_pkg::ST_IDLE;
        end
        rcb_pkg::ST_MRD: begin
          ram_re_r <= 1'b1;
          ram_addr_r <= desc_r;
          state_r <= rcb_pkg::ST_MWAIT;
        end
        rcb_pkg::ST_MWAIT: begin
          state_r <= rcb_pkg::ST_MCAP;
        end
        rcb_pkg::ST_MCAP: begin
          ctrl_r <= ram_rdata;
          state_r <= (ram_rdata[rcb_pkg::CTL_ACCESS] && irq_en_r[rcb_pkg::IRQ_ACCESS]
                      && !(cmd_r.broadcast_indicator && cmd_r.tr && cmd_r.wc_mc[4])) ? rcb_pkg::ST_LOG0 : rcb_pkg::ST_IDLE;
        end
        rcb_pkg::ST_LOG0: begin
          ram_we_r <= 1'b1;
          ram_addr_r <= log_base_r + {11'h000, log_ptr_r, 1'b0};
          ram_wdata_r <= rcb_pkg::IIW_ACCESS;
          state_r <= rcb_pkg::ST_LOG1;
        end
        rcb_pkg::ST_LOG1: begin
          ram_we_r <= 1'b1;
          ram_addr_r <= log_base_r + {11'h000, log_ptr_r, 1'b1};
          ram_wdata_r <= desc_r;
          log_ptr_r <= log_ptr_r + 4'h1;
          set_access_r <= 1'b1;
          state_r <= rcb_pkg::ST_IDLE;
        end
        default: state_r <= rcb_pkg::ST_IDLE;
      endcase
    end
  end

  // ************************************************************
  // Mode response and status
  // ************************************************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      resp_valid <= 1'b0;
      resp <= '0;
      msg_error_status_r <= 1'b0;
    end else begin
      resp_valid <= 1'b0;
      if (state_r == rcb_pkg::ST_IDLE && cmd_valid && is_mode && recognized) begin
        resp_valid <= 1'b1;
        // Table bit picks form of answer
        resp.respond <= !cmd.broadcast_indicator;
        resp.msg_error <= ill_bit;
        // Legal non-broadcast transmit codes 16 to 31 send data
        resp.send_data <= !ill_bit && !cmd.broadcast_indicator && cmd.tr && cmd.wc_mc[4];
        resp.dyn_bus_accept <= 1'b0;
        msg_error_status_r <= ill_bit;
      end else if (state_r == rcb_pkg::ST_XFER && msg_end) begin
        msg_error_status_r <= msg_stat.illegal;
      end
    end
  end

  // ************************************************************
  // Transmit word return and interrupt output
  // ************************************************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      txp_r <= 2'b00;
      tx_word <= rcb_pkg::ZERO16;
      tx_word_valid <= 1'b0;
    end else begin
      txp_r <= {txp_r[0], state_r == rcb_pkg::ST_XFER && tx_word_req && cmd_r.tr && !cmd_r.broadcast_indicator};
      tx_word_valid <= txp_r[1];
      if (txp_r[1]) begin
        tx_word <= ram_rdata;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      message_irq_output <= 1'b0;
    end else begin
      message_irq_output <= |(pend_r & irq_en_r);
    end
  end

  assign ram_addr = ram_addr_r;
  assign ram_wdata = ram_wdata_r;
  assign ram_we = ram_we_r;
  assign ram_re = ram_re_r;

endmodule

// *** rcb_pkg.sv ***
// Constants, register map and carrier types for the circular buffer and mode command block.
// Assumes a 16-bit shared RAM with word addressing and a 16-bit register port.
package rcb_pkg;

  // ************************************************************
  // Widths
  // ************************************************************
  localparam int DW = 16;
  localparam int LOGW = 4;

  // ************************************************************
  // Register map (word offsets on the register port)
  // ************************************************************
  localparam logic [3:0] REG_CFG = 4'h0;
  localparam logic [3:0] REG_IRQ_EN = 4'h1;
  localparam logic [3:0] REG_PEND = 4'h2;
  localparam logic [3:0] REG_DESC_BASE = 4'h3;
  localparam logic [3:0] REG_LOG_BASE = 4'h4;
  localparam logic [3:0] REG_STATUS = 4'h5;
  localparam logic [3:0] REG_ILL_FIRST = 4'h8;

  // Configuration bits
  localparam int CFG_UNDEF_INV = 0;
  localparam int CFG_SEGREGATE = 1;
  localparam int CFG_ERR_FREE = 2;
  localparam int CFG_BROADCAST_INDICATOR_FLAG = 3;

  // Interrupt enable and pending bits
  localparam int IRQ_BLOCK_DONE = 0;
  localparam int IRQ_ACCESS = 1;

  // Descriptor control word fields
  localparam int CTL_CNT_LSB = 4;
  localparam int CTL_BLOCK_DONE = 2;
  localparam int CTL_ACCESS = 15;

  // Descriptor layout
  localparam logic [15:0] DESC_MODE_OFS = 16'h0080;
  localparam logic [2:0] DESC_WORDS = 3'h4;
  localparam logic [15:0] DESC_CA_OFS = 16'h0002;
  localparam logic [15:0] DESC_MIB_OFS = 16'h0003;

  // Message information word fields
  localparam int MIW_ERROR = 15;
  localparam int MIW_BUSY = 14;
  localparam int MIW_BROADCAST_INDICATOR = 13;
  localparam int MIW_ILLEGAL = 12;

  // Interrupt information word type bits
  localparam logic [15:0] IIW_ACCESS = 16'h0002;
  localparam logic [15:0] IIW_BLOCK_DONE = 16'h0001;

  // Reset values
  localparam logic [15:0] CFG_RST = 16'h0000;
  localparam logic [15:0] ZERO16 = 16'h0000;

  // ************************************************************
  // Carrier types
  // ************************************************************
  typedef struct packed {
    logic broadcast_indicator;
    logic tr;
    logic [4:0] sa;
    logic [4:0] wc_mc;
  } rcb_cmd_t;

  typedef struct packed {
    logic error;
    logic busy;
    logic illegal;
    logic gap_err;
  } rcb_msg_stat_t;

  typedef struct packed {
    logic respond;
    logic msg_error;
    logic send_data;
    logic dyn_bus_accept;
  } rcb_resp_t;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0000,
    ST_DESC = 4'b0001,
    ST_XFER = 4'b0010,
    ST_MIW = 4'b0011,
    ST_TT = 4'b0100,
    ST_CA = 4'b0101,
    ST_MIB = 4'b0110,
    ST_MRD = 4'b0111,
    ST_MWAIT = 4'b1000,
    ST_MCAP = 4'b1001,
    ST_LOG0 = 4'b1010,
    ST_LOG1 = 4'b1011
  } rcb_state_t;

endpackage

// *** rcb_ram_model.sv ***
// Shared RAM model standing on the far side of the circular buffer core.
// Assumes word addresses below 4096 and a read answered one cycle after its strobe.
`timescale 1ns/10ps

module rcb_ram_model (
  input wire logic clk,
  input wire logic [15:0] ram_addr,
  input wire logic [15:0] ram_wdata,
  input wire logic ram_we,
  input wire logic ram_re,
  output logic [15:0] ram_rdata
);
  // ************************************************************
  // Storage
  // ************************************************************
  logic [15:0] mem [0:4095];

  initial begin
    for (int i = 0; i < 4096; i++) begin
      mem[i] = 16'h0000;
    end
  end

  // Data only valid after a read; toggles otherwise so stale use shows up
  always @(posedge clk) begin
    if (ram_we) begin
      mem[ram_addr[11:0]] <= ram_wdata;
    end
    ram_rdata <= ram_re ? mem[ram_addr[11:0]] : ~ram_rdata;
  end
endmodule

// *** rcb_checker.sv ***
// Port-level assertions for the circular buffer and mode command core.
// Assumes it is bound to rcb_core and sees only the core's ports.
`timescale 1ns/10ps

module rcb_checker (
  input wire logic clk,
  input wire logic rst,
  input wire logic cmd_valid,
  input wire rcb_pkg::rcb_cmd_t cmd,
  input wire logic rx_word_valid,
  input wire logic [15:0] rx_word,
  input wire logic tx_word_req,
  input wire logic tx_word_valid,
  input wire logic [15:0] tx_word,
  input wire logic msg_end,
  input wire logic [15:0] time_tag,
  input wire logic resp_valid,
  input wire rcb_pkg::rcb_resp_t resp,
  input wire logic [15:0] ram_addr,
  input wire logic [15:0] ram_wdata,
  input wire logic ram_we,
  input wire logic [15:0] ram_rdata,
  input wire logic message_irq_output
);
  // ************************************************************
  // Properties
  // ************************************************************
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  sequence info_pair;
    ram_we ##1 (ram_we && ram_addr == $past(ram_addr) + 16'h0001 && ram_wdata == $past(time_tag, 3));
  endsequence

  info_pair_a: assert property (msg_end |-> ##2 info_pair)
    else $error("info and time tag writes missing");
  rx_store_a: assert property (rx_word_valid |=> ram_we && ram_wdata == $past(rx_word))
    else $error("received word not stored");
  tx_fetch_a: assert property (tx_word_valid |-> $past(tx_word_req, 3) && tx_word == $past(ram_rdata))
    else $error("transmit word not from ram");
  resp_cause_a: assert property (resp_valid |-> $past(cmd_valid) && $past(cmd.sa == 5'h00 || cmd.sa == 5'h1f))
    else $error("answer without mode command");
  resp_broadcast_indicator_a: assert property (resp_valid |-> resp.respond == !$past(cmd.broadcast_indicator))
    else $error("response flag wrong");
  send_data_a: assert property (resp_valid |-> resp.send_data ==
    (!resp.msg_error && $past(cmd.tr && cmd.wc_mc[4] && !cmd.broadcast_indicator)))
    else $error("mode data word decision wrong");
  dyn_bus_a: assert property (resp_valid |-> !resp.dyn_bus_accept)
    else $error("bus control acceptance set");
  irq_after_log_a: assert property ($rose(message_irq_output) |-> $past(ram_we, 2))
    else $error("interrupt without preceding write");
endmodule

bind rcb_core rcb_checker rcb_checker_inst (
  .clk(clk), .rst(rst), .cmd_valid(cmd_valid), .cmd(cmd), .rx_word_valid(rx_word_valid), .rx_word(rx_word),
  .tx_word_req(tx_word_req), .tx_word_valid(tx_word_valid), .tx_word(tx_word), .msg_end(msg_end),
  .time_tag(time_tag), .resp_valid(resp_valid), .resp(resp), .ram_addr(ram_addr), .ram_wdata(ram_wdata),
  .ram_we(ram_we), .ram_rdata(ram_rdata), .message_irq_output(message_irq_output)
);

// *** tb_top.sv ***
// Self-checking bench for rcb_core with a shared RAM model.
// Assumes descriptor base 0x0100, log base 0x0500, RAM below 4096 words.
`timescale 1ns/10ps

module tb_top;
  // ************************************************************
  // Signals and model state
  // ************************************************************
  logic clk, rst, reg_wr, reg_rd, cmd_valid, rx_word_valid, tx_word_req, tx_word_valid, msg_end;
  logic resp_valid, ram_we, ram_re, irq;
  logic [3:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata, rx_word, tx_word, time_tag, ram_addr, ram_wdata, ram_rdata, v;
  rcb_pkg::rcb_cmd_t cmd;
  rcb_pkg::rcb_msg_stat_t msg_stat;
  rcb_pkg::rcb_resp_t resp;
  logic [15:0] ca_m [2], mib_m [2], st_m [2], ctl_m [2], ill_m [8], cfg_m;
  logic [15:0] tx_q [$];
  rcb_pkg::rcb_resp_t resp_q [$];
  int n_errors = 0;
  int comparisons = 0;
  int cycles = 0;
  int log_m = 0;

  rcb_core rcb_core_inst (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cmd_valid(cmd_valid), .cmd(cmd), .rx_word_valid(rx_word_valid),
    .rx_word(rx_word), .tx_word_req(tx_word_req), .tx_word_valid(tx_word_valid), .tx_word(tx_word),
    .msg_end(msg_end), .msg_stat(msg_stat), .time_tag(time_tag), .resp_valid(resp_valid), .resp(resp),
    .ram_addr(ram_addr), .ram_wdata(ram_wdata), .ram_we(ram_we), .ram_re(ram_re), .ram_rdata(ram_rdata),
    .message_irq_output(irq));
  rcb_ram_model rcb_ram_model_inst (.clk(clk), .ram_addr(ram_addr), .ram_wdata(ram_wdata), .ram_we(ram_we),
    .ram_re(ram_re), .ram_rdata(ram_rdata));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Collect one-cycle outputs so no pulse is missed between checks
  always @(posedge clk) begin
    cycles++;
    if (tx_word_valid === 1'b1) tx_q.push_back(tx_word);
    if (resp_valid === 1'b1) resp_q.push_back(resp);
    if (cycles == 30000) begin
      n_errors++;
      test_done();
    end
  end

  // ************************************************************
  // Tasks
  // ************************************************************
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic test_done();
    $display("comparisons %0d mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic check16(input string nm, input logic [15:0] e, input logic [15:0] g);
    comparisons++;
    if (g !== e) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic check_resp(input rcb_pkg::rcb_resp_t e, input rcb_pkg::rcb_resp_t g);
    comparisons++;
    if (g !== e) begin
      n_errors++;
      $display("mismatch resp expected %h seen %h", e, g);
    end
  endtask

  function automatic logic [15:0] mrd(input logic [15:0] a);
    return rcb_ram_model_inst.mem[a[11:0]];
  endfunction

  function automatic logic [15:0] dsc(input logic t);
    return t ? 16'h0188 : 16'h0104;
  endfunction

  // Extra cycle at the end so back-to-back calls never re-drive a strobe in one step
  task automatic reg_write(input logic [3:0] a, input logic [15:0] d);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    tick(1);
    reg_wr <= 1'b0;
    tick(1);
  endtask

  task automatic reg_read(input logic [3:0] a, output logic [15:0] d);
    reg_rd <= 1'b1;
    reg_addr <= a;
    tick(1);
    reg_rd <= 1'b0;
    tick(1);
    d = reg_rdata;
  endtask

  task automatic send_cmd(input logic bc, input logic tr, input logic [4:0] sa, input logic [4:0] m);
    cmd_valid <= 1'b1;
    cmd <= '{broadcast_indicator: bc, tr: tr, sa: sa, wc_mc: m};
    tick(1);
    cmd_valid <= 1'b0;
  endtask

  task automatic run_msg(input logic tr, input logic bc, input logic err);
    int n;
    logic [15:0] mask, tt, info;
    logic [15:0] dq [$];
    logic g, full;
    n = 1 + $urandom % 4;
    tt = 16'($urandom);
    g = 1'($urandom);
    mask = (16'h0001 << ctl_m[tr][7:4]) - 16'h0001;
    tx_q.delete();
    send_cmd(bc, tr, tr ? 5'h02 : 5'h01, 5'(n));
    tick(7);
    for (int i = 0; i < n; i++) begin
      if (tr) begin
        tx_word_req <= 1'b1;
        tick(1);
        tx_word_req <= 1'b0;
        tick(3);
      end else begin
        dq.push_back(16'($urandom));
        rx_word_valid <= 1'b1;
        rx_word <= dq[i];
        tick(1);
      end
    end
    rx_word_valid <= 1'b0;
    msg_end <= 1'b1;
    msg_stat <= '{error: err, busy: 1'b0, illegal: 1'b0, gap_err: g};
    time_tag <= tt;
    tick(1);
    msg_end <= 1'b0;
    time_tag <= ~tt;
    tick(12);
    info = {err, 1'b0, cfg_m[3] ? bc : g, 1'b0, 7'h00, 5'(n)};
    check16("info word", info, mrd(mib_m[tr]));
    check16("time tag", tt, mrd(mib_m[tr] + 16'h0001));
    for (int i = 0; i < n && !tr; i++) check16("rx data", dq[i], mrd(ca_m[tr] + 16'(i)));
    if (tr) check16("tx count", (bc ? 16'h0000 : 16'(n)), 16'(tx_q.size()));
    for (int i = 0; i < tx_q.size(); i++) check16("tx data", mrd(ca_m[tr] + 16'(i)), tx_q[i]);
    full = 1'b0;
    if (!err && !(bc && tr)) begin
      full = ((mib_m[tr] + 16'h0001) & mask) == mask;
      ca_m[tr] = full ? st_m[tr] : ca_m[tr] + 16'(n);
      mib_m[tr] = full ? (mib_m[tr] & ~mask) : mib_m[tr] + 16'h0002;
    end
    check16("data pointer", ca_m[tr], mrd(dsc(tr) + 16'h0002));
    check16("info pointer", mib_m[tr], mrd(dsc(tr) + 16'h0003));
    check16("block irq", {15'h0000, full & ctl_m[tr][2]}, {15'h0000, irq});
    reg_write(4'h2, 16'h0003);
  endtask

  task automatic run_mode(input logic bc, input logic tr, input logic [4:0] mc);
    logic undef, ill, acc;
    logic [6:0] idx;
    idx = {bc, tr, mc};
    undef = tr ? (mc == 5'd17 || mc == 5'd20 || mc == 5'd21) : (mc <= 5'd16 || mc == 5'd18 || mc == 5'd19);
    ill = ill_m[idx[6:4]][idx[3:0]];
    acc = tr && mc == 5'h02 && !(undef && cfg_m[0]);
    resp_q.delete();
    send_cmd(bc, tr, 5'h1f, mc);
    tick(10);
    if (undef && cfg_m[0]) begin
      check16("resp count", 16'h0000, 16'(resp_q.size()));
    end else begin
      check16("resp count", 16'h0001, 16'(resp_q.size()));
      check_resp('{respond: !bc, msg_error: ill, send_data: !ill && !bc && tr && mc[4], dyn_bus_accept: 1'b0},
                 resp_q[0]);
    end
    if (acc) begin
      check16("log info", rcb_pkg::IIW_ACCESS, mrd(16'h0500 + 16'(2 * log_m)));
      check16("log addr", 16'h0208, mrd(16'h0501 + 16'(2 * log_m)));
      check16("access irq", 16'h0001, {15'h0000, irq});
      log_m = (log_m + 1) % 16;
      reg_write(4'h2, 16'h0003);
    end
  endtask

  // ************************************************************
  // Main sequence
  // ************************************************************
  initial begin
    rst = 1'b1;
    reg_addr = 4'h0;
    reg_wdata = 16'h0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    cmd_valid = 1'b0;
    cmd = '0;
    rx_word_valid = 1'b0;
    rx_word = 16'h0000;
    tx_word_req = 1'b0;
    msg_end = 1'b0;
    msg_stat = '0;
    time_tag = 16'h0000;
    ill_m = '{default: 16'h0000};
    ctl_m = '{16'h0024, 16'h0020};
    st_m = '{16'h0400, 16'h0600};
    ca_m = st_m;
    mib_m = '{16'h0300, 16'h0340};
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    tick(1);
    void'($urandom(56393));
    for (int a = 0; a < 16; a++) begin
      reg_read(4'(a), v);
      check16("reset reg", 16'h0000, v);
    end
    $display("reset test done");
    for (int t = 0; t < 2; t++) begin
      for (int w = 0; w < 4; w++) begin
        rcb_ram_model_inst.mem[dsc(1'(t)) + 16'(w)] = (w == 0) ? ctl_m[t] : (w == 3) ? mib_m[t] : st_m[t];
      end
    end
    for (int i = 0; i < 16; i++) rcb_ram_model_inst.mem[12'h600 + 12'(i)] = 16'($urandom);
    rcb_ram_model_inst.mem[12'h208] = 16'h8000;
    reg_write(4'h3, 16'h0100);
    reg_write(4'h4, 16'h0500);
    reg_write(4'h1, 16'h0003);
    cfg_m = 16'h0008;
    reg_write(4'h0, cfg_m);
    run_msg(1'b0, 1'b0, 1'b0);
    run_msg(1'b0, 1'b1, 1'b0);
    run_msg(1'b0, 1'b0, 1'b1);
    run_msg(1'b0, 1'b0, 1'b0);
    $display("receive test done");
    cfg_m = 16'h0000;
    reg_write(4'h0, cfg_m);
    run_msg(1'b1, 1'b0, 1'b0);
    run_msg(1'b1, 1'b1, 1'b0);
    run_msg(1'b1, 1'b0, 1'b0);
    $display("transmit test done");
    cfg_m = 16'h0001;
    reg_write(4'h0, cfg_m);
    for (int k = 0; k < 64; k++) run_mode(1'($urandom), k[5], k[4:0]);
    cfg_m = 16'h0000;
    reg_write(4'h0, cfg_m);
    ill_m[3] = 16'h0004;
    reg_write(4'hb, ill_m[3]);
    for (int k = 0; k < 64; k++) run_mode(1'b0, k[5], k[4:0]);
    $display("mode test done");
    test_done();
  end
endmodule
